// file: rtl/vusr_pkg.sv
// shared constants for the vector unit state registers
package vusr_pkg;
  localparam int VR_COUNT = 32;
  localparam int VR_WIDTH = 128;
  localparam int VR_IDX_W = 5;
  localparam int WORD_W = 32;
  // special register number of the usage mask
  localparam logic [9:0] SPR_USAGE_MASK = 10'h100;
  // status word bit positions, big-endian numbering (bit 0 is msb)
  localparam int MODE_BIT_BE = 15;
  localparam int CLAMP_BIT_BE = 31;
  // little-endian positions inside the 32-bit word
  localparam int MODE_POS = WORD_W - 1 - MODE_BIT_BE;
  localparam int CLAMP_POS = WORD_W - 1 - CLAMP_BIT_BE;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [3:0] FIELD6_RESET = 4'h0;
  // condition field 6 bit layout: all-true, spare, none-true, spare
  localparam int FIELD6_ALL = 3;
  localparam int FIELD6_NONE = 1;
  // issue subunits
  typedef enum logic [3:0] {
    VUSR_U_PERM = 4'b0001,
    VUSR_U_CINT = 4'b0010,
    VUSR_U_SINT = 4'b0100,
    VUSR_U_FLT = 4'b1000
  } vusr_unit_e;
  // single-precision field limits
  localparam int FP_EXP_LSB = 23;
  localparam logic [7:0] FP_EXP_ZERO = 8'h00;
endpackage : vusr_pkg

// file: rtl/vusr_fp_lane.sv
// one 32-bit float lane: flush denormal inputs and underflowed results
`timescale 1ns/1ns
`default_nettype none
module vusr_fp_lane
  import vusr_pkg::*;
(
  input wire logic non_strict,
  input wire logic [31:0] src_in,
  input wire logic [31:0] res_in,
  input wire logic res_uflow,
  output logic [31:0] src_out,
  output logic [31:0] res_out,
  output logic denorm_seen
);
  logic src_denorm;
  // denormal: zero exponent, nonzero fraction
  assign src_denorm = (src_in[30:FP_EXP_LSB] == FP_EXP_ZERO) &&
                      (src_in[FP_EXP_LSB-1:0] != 23'h000000);
  assign src_out = (non_strict && src_denorm) ? {src_in[31], 31'h0} : src_in;
  assign res_out = (non_strict && res_uflow) ? {res_in[31], 31'h0} : res_in;
  // strict mode flags denormal for assist
  assign denorm_seen = !non_strict && src_denorm;
endmodule : vusr_fp_lane
`default_nettype wire

// file: rtl/vusr_state_regs.sv
// architectural state of the 128-bit vector extension
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - 32 registers of 128 bits, byte, halfword or word elements.
// - 128-bit paths split into permute, complex, simple, float subunits.
// - compare with record bit updates condition field 6, user mode allowed.
// - unit-available bit resets to zero; only privileged write sets it.
// - status word moves to and from low bits of a vector register.
// - reserved status bits accept writes; zero written reads zero.
// - bit 15 zero is strict mode; denormals raise an assist.
// - non-strict mode replaces denormal sources with signed zero.
// - non-strict mode writes underflowed results as signed zero.
// - bit 31 sticky saturation, cleared only by status write.
// - any saturating element op sets the saturation flag.
// - usage mask is special register 256, software only.
// - second queue entry to simple unit may pass a stalled lowest.
// - the four thread-management special registers are absent.
module vusr_state_regs
  import vusr_pkg::*;
#(
  parameter int LANES = VR_WIDTH / WORD_W
) (
  input wire logic sys_clk,
  input wire logic rst,
  // register write port from execution
  input wire logic vr_we,
  input wire logic [VR_IDX_W-1:0] vr_waddr,
  input wire logic [VR_WIDTH-1:0] vr_wdata,
  input wire logic [VR_WIDTH/8-1:0] vr_wbe,
  input wire logic [VR_IDX_W-1:0] vr_raddr,
  output logic [VR_WIDTH-1:0] vr_rdata,
  // float lane conditioning
  input wire logic [VR_WIDTH-1:0] fp_src,
  input wire logic [VR_WIDTH-1:0] fp_res,
  input wire logic [LANES-1:0] fp_uflow,
  output logic [VR_WIDTH-1:0] fp_src_clean,
  output logic [VR_WIDTH-1:0] fp_res_clean,
  output logic assist_req,
  // status word moves and saturation events
  input wire logic status_to_vr,
  input wire logic [VR_IDX_W-1:0] status_vr_idx,
  input wire logic status_from_vr,
  input wire logic clamp_event,
  output logic non_strict_float_mode,
  output logic clamp_occurred_flag,
  // special register access
  input wire logic spr_we,
  input wire logic spr_re,
  input wire logic [9:0] spr_num,
  input wire logic [31:0] spr_wdata,
  output logic [31:0] spr_rdata,
  output logic spr_ack,
  output logic spr_illegal,
  // machine state write, privileged
  input wire logic msw_we,
  input wire logic msw_priv,
  input wire logic msw_vec_val,
  output logic vector_unit_available,
  // compare record
  input wire logic cmp_rec,
  input wire logic cmp_all_true,
  input wire logic cmp_none_true,
  output logic [3:0] condition_flags_f6,
  // issue selection from the two lowest entries
  input wire logic ooo_enable,
  input wire logic q0_valid,
  input wire logic q0_ready,
  input wire logic q1_valid,
  input wire logic q1_ready,
  input wire logic [3:0] q1_unit,
  output logic issue_q0,
  output logic issue_q1
);
  // elaboration check: lanes must tile the register width exactly
  if (LANES * WORD_W != VR_WIDTH) begin : g_bad_lanes
    $error("lane count must tile 128 bits");
  end

  // bank of 32 wide registers in flip-flops
  logic [VR_WIDTH-1:0] bank_ff [VR_COUNT];
  logic [VR_WIDTH-1:0] nxt_bank [VR_COUNT];
  logic [VR_WIDTH-1:0] vr_rdata_ff, nxt_vr_rdata;
  logic [31:0] status_ff, nxt_status;
  logic [31:0] mask_ff, nxt_mask;
  logic [31:0] spr_rdata_ff, nxt_spr_rdata;
  logic spr_ack_ff, nxt_spr_ack;
  logic spr_ill_ff, nxt_spr_ill;
  logic avail_ff, nxt_avail;
  logic [3:0] field6_ff, nxt_field6;
  logic issue_q0_ff, nxt_issue_q0;
  logic issue_q1_ff, nxt_issue_q1;
  logic [VR_WIDTH-1:0] src_c, res_c;
  logic [VR_WIDTH-1:0] src_ff, res_ff;
  logic [LANES-1:0] denorm;
  logic assist_ff;

  // float subunit lanes, 128 bits wide
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    vusr_fp_lane u_lane (
      .non_strict(status_ff[MODE_POS]),
      .src_in(fp_src[g*WORD_W +: WORD_W]),
      .res_in(fp_res[g*WORD_W +: WORD_W]),
      .res_uflow(fp_uflow[g]),
      .src_out(src_c[g*WORD_W +: WORD_W]),
      .res_out(res_c[g*WORD_W +: WORD_W]),
      .denorm_seen(denorm[g])
    );
  end

  // vector bank next state; the status move lands in the low word
  always_comb begin
    for (int i = 0; i < VR_COUNT; i++) begin
      nxt_bank[i] = bank_ff[i];
    end
    if (vr_we) begin
      for (int b = 0; b < VR_WIDTH / 8; b++) begin
        if (vr_wbe[b]) begin
          nxt_bank[vr_waddr][b*8 +: 8] = vr_wdata[b*8 +: 8];
        end
      end
    end
    // status word copied to low bits, upper bits zero
    if (status_to_vr) begin
      nxt_bank[status_vr_idx] = {{(VR_WIDTH-WORD_W){1'b0}}, status_ff};
    end
    nxt_vr_rdata = bank_ff[vr_raddr];
  end

  // status word next state
  always_comb begin
    nxt_status = status_ff;
    // reserved bits simply store what was written
    // new mode seen by every later instruction
    if (status_from_vr) begin
      nxt_status = bank_ff[status_vr_idx][WORD_W-1:0];
    end
    // sticky flag, set wins over a clearing write
    if (clamp_event) begin
      nxt_status[CLAMP_POS] = 1'b1;
    end
  end

  // special registers, machine state and compare field
  always_comb begin
    nxt_mask = mask_ff;
    nxt_spr_rdata = spr_rdata_ff;
    nxt_spr_ack = 1'b0;
    nxt_spr_ill = 1'b0;
    // usage mask, touched only by software
    if (spr_num == SPR_USAGE_MASK) begin
      nxt_spr_ack = spr_we || spr_re;
      if (spr_we) begin
        nxt_mask = spr_wdata;
      end
      if (spr_re) begin
        nxt_spr_rdata = mask_ff;
      end
    end else begin
      nxt_spr_ill = spr_we || spr_re;
    end
    // only a privileged write changes availability
    nxt_avail = avail_ff;
    if (msw_we && msw_priv) begin
      nxt_avail = msw_vec_val;
    end
    nxt_field6 = field6_ff;
    if (cmp_rec) begin
      nxt_field6 = 4'h0;
      nxt_field6[FIELD6_ALL] = cmp_all_true;
      nxt_field6[FIELD6_NONE] = cmp_none_true;
    end
  end

  // issue choice between the two lowest queue entries
  always_comb begin
    nxt_issue_q0 = q0_valid && q0_ready;
    // simple-integer op passes a stalled lowest entry
    nxt_issue_q1 = ooo_enable && q1_valid && q1_ready &&
                   (q1_unit == VUSR_U_SINT) && q0_valid && !q0_ready;
  end

  // registers only
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < VR_COUNT; i++) begin
      bank_ff[i] <= nxt_bank[i];
    end
    vr_rdata_ff <= nxt_vr_rdata;
    src_ff <= src_c;
    res_ff <= res_c;
    mask_ff <= nxt_mask;
    if (rst) begin
      status_ff <= STATUS_RESET;
      spr_rdata_ff <= MASK_RESET;
      spr_ack_ff <= 1'b0;
      spr_ill_ff <= 1'b0;
      avail_ff <= 1'b0;
      field6_ff <= FIELD6_RESET;
      issue_q0_ff <= 1'b0;
      issue_q1_ff <= 1'b0;
      assist_ff <= 1'b0;
      vr_rdata_ff <= '0;
      src_ff <= '0;
      res_ff <= '0;
      mask_ff <= MASK_RESET;
    end else begin
      status_ff <= nxt_status;
      spr_rdata_ff <= nxt_spr_rdata;
      spr_ack_ff <= nxt_spr_ack;
      spr_ill_ff <= nxt_spr_ill;
      avail_ff <= nxt_avail;
      field6_ff <= nxt_field6;
      issue_q0_ff <= nxt_issue_q0;
      issue_q1_ff <= nxt_issue_q1;
      assist_ff <= |denorm;
    end
  end

  // outputs straight from flip-flops
  assign vr_rdata = vr_rdata_ff;
  assign fp_src_clean = src_ff;
  assign fp_res_clean = res_ff;
  assign assist_req = assist_ff;
  assign non_strict_float_mode = status_ff[MODE_POS];
  assign clamp_occurred_flag = status_ff[CLAMP_POS];
  assign spr_rdata = spr_rdata_ff;
  assign spr_ack = spr_ack_ff;
  assign spr_illegal = spr_ill_ff;
  assign vector_unit_available = avail_ff;
  assign condition_flags_f6 = field6_ff;
  assign issue_q0 = issue_q0_ff;
  assign issue_q1 = issue_q1_ff;
endmodule : vusr_state_regs
`default_nettype wire

// file: verif/vusr_pipe_model.sv
// issue pipeline stand-in feeding the two lowest queue entries
`timescale 1ns/1ns
`default_nettype none
module vusr_pipe_model
  import vusr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic go,
  input wire logic slow,
  input wire logic issue_q0,
  input wire logic issue_q1,
  output logic q0_valid,
  output logic q0_ready,
  output logic q1_valid,
  output logic q1_ready,
  output logic [3:0] q1_unit
);
  // second entry always bound for the simple unit, operands ready
  assign q1_unit = VUSR_U_SINT;
  assign q1_ready = q1_valid;
  // entries retire on issue; slow keeps the lowest waiting on operands
  always_ff @(posedge sys_clk) begin
    q0_ready <= !slow && q0_valid;
    if (rst) {q0_valid, q1_valid} <= 2'b00;
    else if (go) {q0_valid, q1_valid} <= 2'b11;
    else begin
      q0_valid <= q0_valid && !issue_q0;
      q1_valid <= q1_valid && !issue_q1;
    end
  end
endmodule : vusr_pipe_model
`default_nettype wire

// file: verif/vusr_state_monitor.sv
// assertions on the vector state register ports
`timescale 1ns/1ns
`default_nettype none
module vusr_state_monitor
  import vusr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic spr_we,
  input wire logic spr_re,
  input wire logic spr_ack,
  input wire logic spr_illegal,
  input wire logic msw_we,
  input wire logic msw_priv,
  input wire logic msw_vec_val,
  input wire logic vector_unit_available,
  input wire logic clamp_event,
  input wire logic status_from_vr,
  input wire logic clamp_occurred_flag,
  input wire logic cmp_rec,
  input wire logic cmp_all_true,
  input wire logic cmp_none_true,
  input wire logic ooo_enable,
  input wire logic q0_valid,
  input wire logic q0_ready,
  input wire logic q1_valid,
  input wire logic q1_ready,
  input wire logic issue_q0,
  input wire logic issue_q1,
  input wire logic [9:0] spr_num,
  input wire logic [3:0] q1_unit,
  input wire logic [3:0] condition_flags_f6
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // special register answers: one ack or one refusal
  property p_ack;
    (spr_we || spr_re) && spr_num == SPR_USAGE_MASK |=> spr_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_ill;
    (spr_we || spr_re) && spr_num != SPR_USAGE_MASK
      |=> spr_illegal && !spr_ack;
  endproperty
  a_ill: assert property (p_ill) else $error("no refusal");
  // machine state gate only moves on a privileged write
  property p_msw_user;
    msw_we && !msw_priv |=> $stable(vector_unit_available);
  endproperty
  a_msw_user: assert property (p_msw_user) else $error("user set");
  property p_msw_priv;
    msw_we && msw_priv |=> vector_unit_available == $past(msw_vec_val);
  endproperty
  a_msw_priv: assert property (p_msw_priv) else $error("priv lost");
  // sticky saturation flag
  property p_clamp_set;
    clamp_event |=> clamp_occurred_flag;
  endproperty
  a_clamp_set: assert property (p_clamp_set) else $error("flag not set");
  property p_clamp_keep;
    clamp_occurred_flag && !status_from_vr |=> clamp_occurred_flag;
  endproperty
  a_clamp_keep: assert property (p_clamp_keep) else $error("flag lost");
  // compare summary lands in field 6
  property p_cr6;
    cmp_rec |=> condition_flags_f6 ==
      {$past(cmp_all_true), 1'b0, $past(cmp_none_true), 1'b0};
  endproperty
  a_cr6: assert property (p_cr6) else $error("field 6 wrong");
  // simple-unit entry passes a stalled lowest entry
  property p_ooo;
    ooo_enable && q0_valid && !q0_ready && q1_valid && q1_ready &&
      q1_unit == VUSR_U_SINT |=> issue_q1 && !issue_q0;
  endproperty
  a_ooo: assert property (p_ooo) else $error("no bypass");
endmodule : vusr_state_monitor
bind vusr_state_regs vusr_state_monitor u_mon (.*);
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench for the vector unit state registers
`timescale 1ns/1ns
`default_nettype none
module testbench
  import vusr_pkg::*;
;
  logic sys_clk, rst, vr_we, status_to_vr, status_from_vr, clamp_event;
  logic spr_we, spr_re, msw_we, msw_priv, msw_vec_val, cmp_rec, exp_av;
  logic cmp_all_true, cmp_none_true, ooo_enable, go, slow, assist_req;
  logic [4:0] vr_waddr, vr_raddr, status_vr_idx;
  logic [127:0] vr_wdata, fp_src, fp_res, vr_rdata, fp_src_clean;
  logic [127:0] fp_res_clean;
  logic [15:0] vr_wbe;
  logic [3:0] fp_uflow, q1_unit, condition_flags_f6;
  logic [9:0] spr_num;
  logic [31:0] spr_wdata, spr_rdata;
  logic non_strict_float_mode, clamp_occurred_flag, spr_ack, spr_illegal;
  logic vector_unit_available, q0_valid, q0_ready, q1_valid, q1_ready;
  logic issue_q0, issue_q1;
  int miscompares, comparisons;
  vusr_state_regs u_dut (.*);
  vusr_pipe_model u_pipe (.*);
  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [127:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h", $time, got);
    end
  endtask : chk
  // one special register access, answer settled after the next edge
  task automatic special_register(input logic w, input logic [9:0] n,
    input logic [31:0] d);
    @(posedge sys_clk);
    {spr_we, spr_re, spr_num, spr_wdata} <= {w, !w, n, d};
    @(posedge sys_clk);
    {spr_we, spr_re} <= 2'b00;
    #1;
  endtask : special_register
  // junk in the upper lanes shows the status move zero-fills them
  task automatic ld_status(input logic [31:0] d);
    @(posedge sys_clk);
    vr_we <= 1'b1;
    vr_wdata <= {{3{32'hdead_beef}}, d};
    @(posedge sys_clk);
    vr_we <= 1'b0;
    status_from_vr <= 1'b1;
    @(posedge sys_clk);
    status_from_vr <= 1'b0;
    #1;
  endtask : ld_status
  task automatic final_report;
    $display("checks %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  // a hang ends the run as a failure
  initial begin
    repeat (2000) @(posedge sys_clk);
    miscompares++;
    final_report;
  end
  initial begin
    {vr_we, status_to_vr, status_from_vr, clamp_event, spr_we, spr_re} = '0;
    {msw_we, msw_priv, msw_vec_val, cmp_rec, cmp_all_true} = '0;
    {cmp_none_true, ooo_enable, go, slow, vr_raddr, fp_uflow} = '0;
    {fp_src, fp_res, spr_num, spr_wdata, exp_av} = '0;
    {vr_waddr, status_vr_idx, vr_wbe} = {5'h03, 5'h03, 16'hffff};
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    special_register(1'b0, SPR_USAGE_MASK, 32'h0);
    chk(spr_rdata, 32'h0);
    chk({vector_unit_available, clamp_occurred_flag}, 2'b00);
    $display("reset test done");
    special_register(1'b1, SPR_USAGE_MASK, 32'h8000_0005);
    special_register(1'b0, SPR_USAGE_MASK, 32'h0);
    chk(spr_rdata, 32'h8000_0005);
    special_register(1'b1, 10'h101, 32'h0);
    chk({spr_illegal, spr_ack}, 2'b10);
    $display("mask test done");
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      {msw_we, msw_priv, msw_vec_val} <= {1'b1, i[0], !i[1]};
      if (i[0]) exp_av = !i[1];
      @(posedge sys_clk);
      msw_we <= 1'b0;
      #1;
      chk(vector_unit_available, exp_av);
    end
    $display("gate test done");
    ld_status(32'h4001_2000);
    chk({non_strict_float_mode, clamp_occurred_flag}, 2'b10);
    @(posedge sys_clk);
    status_to_vr <= 1'b1;
    vr_raddr <= 5'h03;
    fp_src <= {96'h0, 32'h8000_0001};
    fp_res <= {96'h0, 32'h8012_3456};
    fp_uflow <= 4'h1;
    @(posedge sys_clk);
    status_to_vr <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(vr_rdata, {96'h0, 32'h4001_2000});
    chk(fp_src_clean, {96'h0, 32'h8000_0000});
    chk(fp_res_clean, {96'h0, 32'h8000_0000});
    chk(assist_req, 1'b0);
    ld_status(32'h0);
    @(posedge sys_clk);
    #1;
    chk(assist_req, 1'b1);
    $display("status test done");
    @(posedge sys_clk);
    clamp_event <= 1'b1;
    @(posedge sys_clk);
    {clamp_event, cmp_rec, cmp_all_true} <= 3'b011;
    @(posedge sys_clk);
    {cmp_all_true, cmp_none_true} <= 2'b01;
    #1;
    chk({clamp_occurred_flag, condition_flags_f6}, 5'h18);
    @(posedge sys_clk);
    cmp_rec <= 1'b0;
    #1;
    chk({clamp_occurred_flag, condition_flags_f6}, 5'h12);
    ld_status(32'h0);
    chk(clamp_occurred_flag, 1'b0);
    // saturation in the same cycle as a clearing load: set wins
    @(posedge sys_clk);
    {status_from_vr, clamp_event} <= 2'b11;
    @(posedge sys_clk);
    {status_from_vr, clamp_event} <= 2'b00;
    #1;
    chk(clamp_occurred_flag, 1'b1);
    $display("flag test done");
    @(posedge sys_clk);
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(issue_q0, 1'b1);
    @(posedge sys_clk);
    {slow, ooo_enable, go} <= 3'b111;
    @(posedge sys_clk);
    go <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk({issue_q0, issue_q1}, 2'b01);
    $display("issue test done");
    // single byte lane write leaves the other bytes alone
    @(posedge sys_clk);
    {vr_we, vr_wbe, vr_wdata} <= {1'b1, 16'h0001, {4{32'hffff_ffff}}};
    @(posedge sys_clk);
    vr_we <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(vr_rdata, {{3{32'hdead_beef}}, 32'h0000_00ff});
    $display("bank test done");
    // mid-run reset clears the flag and the usage mask
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk(clamp_occurred_flag, 1'b0);
    special_register(1'b0, SPR_USAGE_MASK, 32'h0);
    chk(spr_rdata, 32'h0);
    $display("second reset test done");
    final_report;
  end
endmodule : testbench
`default_nettype wire
